//--- cbi_defines.svh
// Constants for the processor bus and interrupt interface
`ifndef CBI_DEFINES_SVH
`define CBI_DEFINES_SVH
`define CBI_VEC_TRAP    16'h0024
`define CBI_VEC_R75     16'h003C
`define CBI_VEC_R65     16'h0034
`define CBI_VEC_R55     16'h002C
`define CBI_PC_RESET    16'h0000
`define CBI_T_NORMAL    3'h3
`define CBI_T_FETCH4    3'h4
`define CBI_T_FETCH6    3'h6
`define CBI_T_ONE       3'h1
`define CBI_RIM_SID_BIT 7
`define CBI_MASK_R55    0
`define CBI_MASK_R65    1
`define CBI_MASK_R75    2
`endif

//--- cbi_pkg.sv
// Types for the processor bus and interrupt interface
`default_nettype none
package cbi_pkg;
  // Machine cycle kinds requested by the core
  typedef enum logic [2:0] {
    CBI_CYC_FETCH4 = 3'b000,
    CBI_CYC_FETCH6 = 3'b001,
    CBI_CYC_READ   = 3'b010,
    CBI_CYC_WRITE  = 3'b011,
    CBI_CYC_INTACK = 3'b100
  } cbi_cyc_t;
  // Bus sequencer states
  typedef enum logic [2:0] {
    CBI_ST_IDLE = 3'b000,
    CBI_ST_T1   = 3'b001,
    CBI_ST_T2   = 3'b010,
    CBI_ST_WAIT = 3'b011,
    CBI_ST_T3   = 3'b100,
    CBI_ST_TX   = 3'b101,
    CBI_ST_HOLD = 3'b110
  } cbi_state_t;
  // One machine-cycle request from the core
  typedef struct packed {
    cbi_cyc_t    kind;
    logic        io;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cbi_req_t;
  // Interrupt mask write from the set-mask instruction
  typedef struct packed {
    logic       sod_en;
    logic       sod_val;
    logic       r75_clr;
    logic       mask_en;
    logic [2:0] mask;
  } cbi_sim_t;
endpackage
`default_nettype wire

//--- cbi_bus_irq.sv
// Bus sequencer, interrupt logic, reset and clock output of an 8-bit processor
//
// Design decisions made here: the whole-cycle retake delay after the grant drops.
`include "cbi_defines.svh"
`default_nettype none

module cbi_bus_irq (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              crystal_in,
  output logic                   clk_out,
  output logic                   reset_out,
  input  wire cbi_pkg::cbi_req_t req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output logic                   done,
  output logic [7:0]             rdata,
  input  wire logic              halted,
  input  wire logic              instr_last,
  input  wire logic              ei_set,
  input  wire logic              di_set,
  input  wire cbi_pkg::cbi_sim_t sim,
  input  wire logic              sim_valid,
  input  wire logic              rim_valid,
  output logic [7:0]             rim_data,
  output logic                   irq_take,
  output logic [15:0]            irq_vector,
  output logic                   irq_general,
  output logic [15:0]            pc,
  input  wire logic              pc_inc,
  input  wire logic              pc_load,
  input  wire logic [15:0]       pc_value,
  output logic [7:0]             low_addr_data_lines_o,
  output logic                   low_addr_data_lines_oe_n,
  input  wire logic [7:0]        low_addr_data_lines_i,
  output logic [7:0]             upper_address_lines,
  output logic                   upper_address_oe_n,
  output logic                   addr_latch_en,
  output logic                   read_n,
  output logic                   write_n,
  output logic                   irq_acknowledge_n,
  output logic                   io_mem_sel,
  output logic                   ctrl_oe_n,
  output logic                   cycle_status_bit0,
  output logic                   cycle_status_bit1,
  input  wire logic              ready,
  input  wire logic              hold_req,
  output logic                   bus_grant,
  input  wire logic              general_irq,
  input  wire logic              rst55,
  input  wire logic              rst65,
  input  wire logic              rst75,
  input  wire logic              trap,
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cbi_pkg::cbi_state_t state;        // Bus sequencer state
  cbi_pkg::cbi_req_t   cur;          // Latched cycle in progress
  logic [2:0]          tcount;       // T states spent in this cycle
  logic [2:0]          tlimit;       // T states this cycle lasts
  logic                int_en;       // General interrupt enable
  logic                int_en_saved; // Enable before a trap, for mask read
  logic                trap_seen;    // First mask read after trap pending
  logic [2:0]          mask;         // Restart masks 5.5, 6.5, 7.5
  logic                r75_ff;       // Latched 7.5 request
  logic                r75_prev;     // Previous 7.5 level for edge
  logic                trap_prev;    // Previous trap level
  logic                trap_ff;      // Trap edge latched until taken or the line falls
  logic                retake;       // One-cycle delay after grant drop
  logic                ack_pending;  // Acknowledge cycle owed to core
  logic                sample_ok;    // Interrupt sampling window
  logic                drive;        // Bus owned and driven by us
  logic [15:0]         next_pc;

  // Length of a machine cycle in T states
  function automatic logic [2:0] cyc_len(input cbi_pkg::cbi_cyc_t k);
    case (k)
      cbi_pkg::CBI_CYC_FETCH4: cyc_len = `CBI_T_FETCH4;
      cbi_pkg::CBI_CYC_FETCH6: cyc_len = `CBI_T_FETCH6;
      default:                 cyc_len = `CBI_T_NORMAL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Clock output and reset output
  // ----------------------------------------------------------------
  // Divide the oscillator input by two; clk is already the internal rate
  always_ff @(posedge crystal_in)
  begin
    if (rst)
      clk_out <= 1'b0;
    else
      clk_out <= ~clk_out;
  end

  // Registered so it lasts whole clock periods
  always_ff @(posedge clk)
  begin
    reset_out <= rst;
  end

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  // Grant only between transfers, so a cycle is never cut short
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state  <= cbi_pkg::CBI_ST_IDLE;
      tcount <= 3'h0;
      tlimit <= `CBI_T_NORMAL;
      cur    <= '0;
      retake <= 1'b0;
    end
    else
    begin
      retake <= 1'b0;
      case (state)
        cbi_pkg::CBI_ST_IDLE:
        begin
          if (hold_req)
            state <= cbi_pkg::CBI_ST_HOLD;
          else if (req_valid && !retake)
          begin
            cur    <= req;
            tlimit <= cyc_len(req.kind);
            tcount <= `CBI_T_ONE;
            state  <= cbi_pkg::CBI_ST_T1;
          end
        end
        cbi_pkg::CBI_ST_T1:
        begin
          tcount <= tcount + `CBI_T_ONE;
          state  <= cbi_pkg::CBI_ST_T2;
        end
        cbi_pkg::CBI_ST_T2, cbi_pkg::CBI_ST_WAIT:
        begin
          if (!ready)
            state <= cbi_pkg::CBI_ST_WAIT;
          else
          begin
            tcount <= tcount + `CBI_T_ONE;
            state  <= cbi_pkg::CBI_ST_T3;
          end
        end
        cbi_pkg::CBI_ST_T3, cbi_pkg::CBI_ST_TX:
        begin
          if (tcount >= tlimit)
            state <= hold_req ? cbi_pkg::CBI_ST_HOLD : cbi_pkg::CBI_ST_IDLE;
          else
          begin
            tcount <= tcount + `CBI_T_ONE;
            state  <= cbi_pkg::CBI_ST_TX;
          end
        end
        cbi_pkg::CBI_ST_HOLD:
        begin
          if (!hold_req)
          begin
            state  <= cbi_pkg::CBI_ST_IDLE;
            retake <= 1'b1;
          end
        end
        default: state <= cbi_pkg::CBI_ST_IDLE;
      endcase
    end
  end

  // Read data captured at the end of T3 while the strobe is low
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (state == cbi_pkg::CBI_ST_T3 && cur.kind != cbi_pkg::CBI_CYC_WRITE)
      rdata <= low_addr_data_lines_i;
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Retake is a whole cycle here: the closest safe whole-clock value
  assign drive     = !rst && !halted && state != cbi_pkg::CBI_ST_HOLD && !retake;
  assign bus_grant = state == cbi_pkg::CBI_ST_HOLD;
  assign req_ready = state == cbi_pkg::CBI_ST_IDLE && !hold_req && !retake;
  // Fetch cycles end in a trailing state, so both end states can finish
  assign done      = (state == cbi_pkg::CBI_ST_T3 || state == cbi_pkg::CBI_ST_TX) && tcount >= tlimit;

  always_comb
  begin
    low_addr_data_lines_o    = 8'h00;
    low_addr_data_lines_oe_n = 1'b1;
    read_n                   = 1'b1;
    write_n                  = 1'b1;
    irq_acknowledge_n        = 1'b1;
    if (state == cbi_pkg::CBI_ST_T1)
    begin
      low_addr_data_lines_o    = cur.addr[7:0];
      low_addr_data_lines_oe_n = !drive;
    end
    else if (state == cbi_pkg::CBI_ST_T2 || state == cbi_pkg::CBI_ST_WAIT
             || state == cbi_pkg::CBI_ST_T3)
    begin
      if (cur.kind == cbi_pkg::CBI_CYC_WRITE)
      begin
        low_addr_data_lines_o    = cur.wdata;
        low_addr_data_lines_oe_n = !drive;
        write_n                  = 1'b0;
      end
      else if (cur.kind == cbi_pkg::CBI_CYC_INTACK)
        irq_acknowledge_n = 1'b0;
      else
        read_n = 1'b0;
    end
  end

  assign upper_address_lines = cur.addr[15:8];
  assign upper_address_oe_n  = !drive || state == cbi_pkg::CBI_ST_IDLE;
  assign ctrl_oe_n           = !drive;
  assign io_mem_sel          = cur.io;
  assign addr_latch_en       = state == cbi_pkg::CBI_ST_T1;
  assign cycle_status_bit0   = cur.kind == cbi_pkg::CBI_CYC_WRITE || cur.kind[2];
  assign cycle_status_bit1   = cur.kind != cbi_pkg::CBI_CYC_WRITE;

  // ----------------------------------------------------------------
  // Interrupt sampling and priority
  // ----------------------------------------------------------------
  assign sample_ok = instr_last || halted || bus_grant;

  // Fixed priority and vector choice
  always_comb
  begin
    irq_take    = 1'b0;
    irq_general = 1'b0;
    irq_vector  = `CBI_PC_RESET;
    if (sample_ok && !ack_pending)
    begin
      if (trap_ff)
      begin
        irq_take   = 1'b1;
        irq_vector = `CBI_VEC_TRAP;
      end
      else if (int_en && r75_ff && !mask[`CBI_MASK_R75])
      begin
        irq_take   = 1'b1;
        irq_vector = `CBI_VEC_R75;
      end
      else if (int_en && rst65 && !mask[`CBI_MASK_R65])
      begin
        irq_take   = 1'b1;
        irq_vector = `CBI_VEC_R65;
      end
      else if (int_en && rst55 && !mask[`CBI_MASK_R55])
      begin
        irq_take   = 1'b1;
        irq_vector = `CBI_VEC_R55;
      end
      else if (int_en && general_irq)
      begin
        irq_take    = 1'b1;
        irq_general = 1'b1;
      end
    end
  end

  // Trap needs a fresh rising edge each time, so a stuck line fires once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trap_prev <= 1'b0;
      trap_ff   <= 1'b0;
      r75_prev  <= 1'b0;
      r75_ff    <= 1'b0;
    end
    else
    begin
      trap_prev <= trap;
      r75_prev  <= rst75;
      if (trap && !trap_prev)
        trap_ff <= 1'b1;
      else if (!trap || (irq_take && irq_vector == `CBI_VEC_TRAP))
        trap_ff <= 1'b0;
      // Edge set wins over a same-cycle clear
      if (rst75 && !r75_prev)
        r75_ff <= 1'b1;
      else if ((irq_take && irq_vector == `CBI_VEC_R75) || (sim_valid && sim.r75_clr))
        r75_ff <= 1'b0;
    end
  end

  // Enable, masks and serial output
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      int_en       <= 1'b0;
      int_en_saved <= 1'b0;
      trap_seen    <= 1'b0;
      mask         <= 3'h7;
      serial_out_pin <= 1'b0;
    end
    else
    begin
      if (irq_take)
      begin
        int_en       <= 1'b0;
        int_en_saved <= int_en;
        trap_seen    <= irq_vector == `CBI_VEC_TRAP && !irq_general;
      end
      else if (ei_set)
        int_en <= 1'b1;
      else if (di_set)
        int_en <= 1'b0;
      if (rim_valid)
        trap_seen <= 1'b0;
      if (sim_valid && sim.mask_en)
        mask <= sim.mask;
      if (sim_valid && sim.sod_en)
        serial_out_pin <= sim.sod_val;
    end
  end

  // Mask read value, with the serial input in the top bit
  always_comb
  begin
    rim_data = {serial_in_pin, rst75, rst65, rst55,
                trap_seen ? int_en_saved : int_en, mask};
  end

  // General request owes an acknowledge cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      ack_pending <= 1'b0;
    else if (irq_take && irq_general)
      ack_pending <= 1'b1;
    else if (done && cur.kind == cbi_pkg::CBI_CYC_INTACK)
      ack_pending <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_comb
  begin
    next_pc = pc;
    if (irq_take && !irq_general)
      next_pc = irq_vector;
    else if (pc_load)
      next_pc = pc_value;
    else if (pc_inc && !ack_pending && !irq_take)
      next_pc = pc + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pc <= `CBI_PC_RESET;
    else
      pc <= next_pc;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ale_in_t1_a: assert property (@(posedge clk) disable iff (rst)
    addr_latch_en |-> ##1 !addr_latch_en) else $error("latch strobe longer than one cycle");
  wait_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state == cbi_pkg::CBI_ST_T2 && !ready) |=> state == cbi_pkg::CBI_ST_WAIT)
    else $error("wait not inserted");
  grant_float_a: assert property (@(posedge clk) disable iff (rst)
    bus_grant |-> ctrl_oe_n && low_addr_data_lines_oe_n && upper_address_oe_n)
    else $error("bus driven during grant");
  grant_drop_a: assert property (@(posedge clk) disable iff (rst)
    (bus_grant && !hold_req) |=> !bus_grant) else $error("grant not released");
  retake_gap_a: assert property (@(posedge clk) disable iff (rst)
    $fell(bus_grant) |-> ctrl_oe_n) else $error("bus retaken too early");
  enable_clear_a: assert property (@(posedge clk) disable iff (rst)
    irq_take |=> !int_en) else $error("enable kept after accept");
  trap_prio_a: assert property (@(posedge clk) disable iff (rst)
    (trap_ff && sample_ok && !ack_pending) |-> irq_vector == `CBI_VEC_TRAP)
    else $error("trap not highest");
  r75_latch_a: assert property (@(posedge clk) disable iff (rst)
    $rose(rst75) |=> r75_ff) else $error("7.5 edge lost");
  pc_reset_a: assert property (@(posedge clk)
    rst |=> pc == `CBI_PC_RESET) else $error("pc not cleared");
  cyc_len_a: assert property (@(posedge clk) disable iff (rst)
    (state == cbi_pkg::CBI_ST_T1 && cur.kind == cbi_pkg::CBI_CYC_READ) ##1 ready |=> done)
    else $error("read cycle not three states");
  wait_c: cover property (@(posedge clk) state == cbi_pkg::CBI_ST_WAIT);
  grant_c: cover property (@(posedge clk) $fell(bus_grant));
  trap_c: cover property (@(posedge clk) irq_take && irq_vector == `CBI_VEC_TRAP);

endmodule // cbi_bus_irq
`default_nettype wire

//--- cbi_mem_model.sv
// Memory and peripheral model for the far side of the processor bus
`default_nettype none
module cbi_mem_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] bus_in,
  input  wire logic       addr_latch_en,
  input  wire logic       read_n,
  input  wire logic       write_n,
  input  wire logic       irq_acknowledge_n,
  input  wire logic [3:0] waits,
  output logic [7:0]      drv_d,
  output logic            ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256]; // Byte store, indexed by the latched low address
  logic [7:0] lat;       // Low address caught while the latch strobe is high
  logic [7:0] last;      // Last byte driven; its inverse shows once released
  logic [3:0] cnt;       // Cycles the current strobe has been low
  logic       rd_act;    // Model owns the shared lines
  logic       strobe;    // Any transfer strobe low

  assign rd_act = !read_n || !irq_acknowledge_n;
  assign strobe = rd_act || !write_n;
  // Released lines show the inverse of the last byte, so a stale copy never passes
  assign drv_d  = !irq_acknowledge_n ? 8'hFF : (rd_act ? mem[lat] : ~last);
  // Slow device: ready stays low for the first waits cycles of each strobe
  assign ready  = !strobe || (cnt >= waits);

  // ----------------------------------------------------------
  // Address capture, write store and wait counting
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (addr_latch_en)
    begin
      lat <= bus_in;
    end
    // Store every strobe cycle; the last one wins, so data must hold to the end
    if (!write_n)
    begin
      mem[lat] <= bus_in;
    end
    cnt  <= (rst || !strobe) ? 4'h0 : cnt + 4'h1;
    last <= rst ? 8'hA5 : (rd_act ? drv_d : last);
  end
endmodule // cbi_mem_model
`default_nettype wire

//--- cbi_bus_irq_tb_top.sv
// Self-checking testbench for the processor bus and interrupt block
`default_nettype none
module cbi_bus_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0, rst = 1'b1, crystal_in = 1'b0;
  cbi_pkg::cbi_req_t req = '0;
  cbi_pkg::cbi_sim_t sim = '0;
  logic [15:0]       pc_value = 16'h0000;
  logic [15:0]       irq_vector, pc;
  logic [7:0]        low_addr_data_lines_i, low_addr_data_lines_o, rdata, rim_data, upper_address_lines, mdl_d;
  logic              req_valid = 1'b0, instr_last = 1'b0, ei_set = 1'b0, di_set = 1'b0;
  logic              sim_valid = 1'b0, rim_valid = 1'b0, pc_inc = 1'b0, pc_load = 1'b0;
  logic              hold_req = 1'b0, general_irq = 1'b0, rst55 = 1'b0, rst65 = 1'b0;
  logic              rst75 = 1'b0, trap = 1'b0, serial_in_pin = 1'b0;
  logic              clk_out, reset_out, req_ready, done, irq_take, irq_general, low_addr_data_lines_oe_n;
  logic              upper_address_oe_n, addr_latch_en, read_n, write_n, irq_acknowledge_n, ctrl_oe_n;
  logic              bus_grant, serial_out_pin, ready, io_mem_sel, halted = 1'b0;
  logic [3:0]        waits = 4'h0;                  // Wait cycles the model inserts
  logic [15:0]       vecs [3] = '{16'h003C, 16'h0034, 16'h002C};
  int                err_count = 0, total_checks = 0, ncry = 0, nout = 0, c0, o0;

  cbi_bus_irq cbi_bus_irq_inst (
    .clk, .rst, .crystal_in, .clk_out, .reset_out, .req, .req_valid, .req_ready, .done, .rdata,
    .halted, .instr_last, .ei_set, .di_set, .sim, .sim_valid, .rim_valid, .rim_data,
    .irq_take, .irq_vector, .irq_general, .pc, .pc_inc, .pc_load, .pc_value,
    .low_addr_data_lines_o, .low_addr_data_lines_oe_n, .low_addr_data_lines_i,
    .upper_address_lines, .upper_address_oe_n, .addr_latch_en, .read_n, .write_n,
    .irq_acknowledge_n, .io_mem_sel, .ctrl_oe_n, .cycle_status_bit0(), .cycle_status_bit1(),
    .ready, .hold_req, .bus_grant, .general_irq, .rst55, .rst65, .rst75, .trap,
    .serial_in_pin, .serial_out_pin
  );
  cbi_mem_model cbi_mem_model_inst (
    .clk, .rst, .bus_in(low_addr_data_lines_i), .addr_latch_en, .read_n, .write_n,
    .irq_acknowledge_n, .waits, .drv_d(mdl_d), .ready
  );
  // Shared lines: the processor wins while it drives, otherwise the model
  assign low_addr_data_lines_i = low_addr_data_lines_oe_n ? mdl_d : low_addr_data_lines_o;

  // ----------------------------------------------------------
  // Clocks and edge counters
  // ----------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) crystal_in <= ~crystal_in;
  always @(posedge crystal_in) ncry++;
  always @(posedge clk_out) nout++;

  // ----------------------------------------------------------
  // Compare, verdict and wait helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Waits for grant or for an accepted interrupt, bounded
  task automatic wait_for(input logic grant);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n > 30)
      begin
        err_count++;
        close_out();
      end
    end while ((grant ? bus_grant : irq_take) !== 1'b1);
  endtask

  // One-cycle pulse on {ei, di, sim_valid, rim_valid, pc_inc, pc_load}
  task automatic core_pulse(input logic [5:0] v);
    @(posedge clk);
    {ei_set, di_set, sim_valid, rim_valid, pc_inc, pc_load} <= v;
    @(posedge clk);
    {ei_set, di_set, sim_valid, rim_valid, pc_inc, pc_load} <= 6'h00;
  endtask

  task automatic chk_reset;
    chk({low_addr_data_lines_oe_n, upper_address_oe_n, ctrl_oe_n, bus_grant, reset_out}, 16'h001D);
    chk(pc, 16'h0000);
    chk(rim_data[3:0], 16'h0007);
  endtask

  // One machine cycle: strb is the expected {read, acknowledge, write} strobes seen
  task automatic bus_op(input cbi_pkg::cbi_cyc_t k, input logic [15:0] a, input logic [7:0] wd,
                        input int cyc, input logic [2:0] strb, input logic hold, input logic [7:0] rd);
    int         n;
    logic [2:0] seen;
    logic       g;
    n    = 0;
    seen = 3'b000;
    g    = 1'b0;
    @(negedge clk);
    chk(req_ready, 16'h0001);
    @(posedge clk);
    req       <= '{kind: k, io: 1'b0, addr: a, wdata: wd};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    hold_req  <= hold;
    do
    begin
      @(negedge clk);
      n++;
      if (n == 1)
      begin
        chk({addr_latch_en, low_addr_data_lines_oe_n, upper_address_oe_n, io_mem_sel}, 16'h0008);
        chk({upper_address_lines, low_addr_data_lines_o}, a);
      end
      g |= bus_grant;
      seen |= {~read_n, ~irq_acknowledge_n, ~write_n};
      if (!write_n)
      begin
        chk({low_addr_data_lines_oe_n, low_addr_data_lines_o}, {8'h00, wd});
      end
      if (n > 20)
      begin
        err_count++;
        close_out();
      end
    end while (done !== 1'b1);
    chk(16'(n), 16'(cyc));
    chk({seen, g}, {strb, 1'b0});
    if (!strb[0])
    begin
      @(negedge clk);
      chk(rdata, rd);
    end
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (9) @(posedge clk);
    @(negedge clk);
    chk_reset();
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk(reset_out, 16'h0000);
    c0 = ncry;
    o0 = nout;
    repeat (40) @(negedge clk);
    chk(16'(ncry - c0), 16'(2 * (nout - o0)));
    $display("end reset and clock");
    // Slow write, then read back, then both fetch lengths
    waits <= 4'h2;
    bus_op(cbi_pkg::CBI_CYC_WRITE, 16'h12A5, 8'hC3, 5, 3'b001, 1'b0, 8'h00);
    waits <= 4'h0;
    bus_op(cbi_pkg::CBI_CYC_READ, 16'h12A5, 8'h00, 3, 3'b100, 1'b0, 8'hC3);
    bus_op(cbi_pkg::CBI_CYC_FETCH4, 16'h12A5, 8'h00, 4, 3'b100, 1'b0, 8'hC3);
    bus_op(cbi_pkg::CBI_CYC_FETCH6, 16'h12A5, 8'h00, 6, 3'b100, 1'b0, 8'hC3);
    $display("end bus cycles");
    // Hold raised mid-transfer: grant only after the cycle ends
    bus_op(cbi_pkg::CBI_CYC_WRITE, 16'h0077, 8'h3C, 3, 3'b001, 1'b1, 8'h00);
    wait_for(1'b1);
    chk({req_ready, low_addr_data_lines_oe_n, upper_address_oe_n, ctrl_oe_n}, 16'h0007);
    @(posedge clk);
    hold_req <= 1'b0;
    @(negedge clk);
    chk(bus_grant, 16'h0001);
    @(negedge clk);
    chk({bus_grant, req_ready, low_addr_data_lines_oe_n}, 16'h0001);
    @(negedge clk);
    chk(req_ready, 16'h0001);
    bus_op(cbi_pkg::CBI_CYC_READ, 16'h0077, 8'h00, 3, 3'b100, 1'b0, 8'h3C);
    $display("end hold");
    // Enable and disable by software
    core_pulse(6'b100000);
    @(negedge clk);
    chk(rim_data[3], 16'h0001);
    core_pulse(6'b010000);
    @(negedge clk);
    chk(rim_data[3], 16'h0000);
    // All restarts pending while masked: nothing taken, 7.5 edge still latched
    core_pulse(6'b100000);
    instr_last <= 1'b1;
    {rst75, rst65, rst55} <= 3'h7;
    @(posedge clk);
    rst75 <= 1'b0;
    repeat (4)
    begin
      @(negedge clk);
      chk(irq_take, 16'h0000);
    end
    @(posedge clk);
    sim <= '{sod_en: 1'b0, sod_val: 1'b0, r75_clr: 1'b0, mask_en: 1'b1, mask: 3'h0};
    core_pulse(6'b001000);
    for (int i = 0; i < 3; i++)
    begin
      wait_for(1'b0);
      chk(irq_vector, vecs[i]);
      @(posedge clk);
      {rst65, rst55} <= (i == 0) ? 2'b11 : ((i == 1) ? 2'b01 : 2'b00);
      @(negedge clk);
      chk(rim_data[3], 16'h0000);
      chk(pc, vecs[i]);
      core_pulse(6'b100000);
    end
    // Trap taken with interrupts disabled; a new 7.5 edge waits behind it
    core_pulse(6'b010000);
    {trap, rst75} <= 2'b11;
    wait_for(1'b0);
    chk(irq_vector, 16'h0024);
    @(posedge clk);
    {trap, rst75} <= 2'b00;
    core_pulse(6'b100000);
    wait_for(1'b0);
    chk(irq_vector, 16'h003C);
    // General request ignored outside the late sampling slot
    @(posedge clk);
    instr_last  <= 1'b0;
    general_irq <= 1'b1;
    core_pulse(6'b100000);
    repeat (3)
    begin
      @(negedge clk);
      chk(irq_take, 16'h0000);
    end
    @(posedge clk);
    instr_last <= 1'b1;
    wait_for(1'b0);
    chk(irq_general, 16'h0001);
    @(posedge clk);
    {general_irq, instr_last} <= 2'b00;
    bus_op(cbi_pkg::CBI_CYC_INTACK, 16'h12A5, 8'h00, 3, 3'b010, 1'b0, 8'hFF);
    $display("end interrupts");
    // Serial output set and held; serial input read back
    @(posedge clk);
    serial_in_pin <= 1'b1;
    sim <= '{sod_en: 1'b1, sod_val: 1'b1, r75_clr: 1'b0, mask_en: 1'b0, mask: 3'h0};
    core_pulse(6'b001000);
    sim <= '0;
    core_pulse(6'b001100);
    @(negedge clk);
    chk({serial_out_pin, rim_data[7]}, 16'h0003);
    // Halt floats the bus even with no grant pending
    @(posedge clk);
    halted <= 1'b1;
    @(negedge clk);
    chk({ctrl_oe_n, upper_address_oe_n, low_addr_data_lines_oe_n}, 16'h0007);
    @(posedge clk);
    halted <= 1'b0;
    $display("end serial");
    // Second reset with a live program counter and interrupts enabled
    pc_value <= 16'hBEEF;
    core_pulse(6'b100001);
    core_pulse(6'b000010);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_reset();
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk(reset_out, 16'h0000);
    $display("end second reset");
    close_out();
  end
endmodule // cbi_bus_irq_tb_top
`default_nettype wire
